// [dsiph_cfg.svh]
`ifndef DSIPH_CFG_SVH
`define DSIPH_CFG_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define DSIPH_SOFT_RESET_CMD    8'h01
`define DSIPH_SLEEP_ENTRY_CMD   8'h10
`define DSIPH_SLEEP_EXIT_CMD    8'h11
`define DSIPH_VERSION_READ_CMD  8'h90
// ----------------------------------------
// staged set-up register offsets
// ----------------------------------------
`define DSIPH_TERM_SEL_OFS      8'hAE
`define DSIPH_GCLK_ADJ_OFS      8'hB2
`define DSIPH_GOE_WIDTH_OFS     8'hB6
`define DSIPH_GATE_SUP_OFS      8'hD2
`define DSIPH_TKEY1_OFS         8'hEE
`define DSIPH_TKEY2_OFS         8'hEF
`define DSIPH_CLK_DRIVE_OFS     8'hF2
// ----------------------------------------
// test-mode key values and reset values
// ----------------------------------------
`define DSIPH_TKEY1_VAL         8'hEA
`define DSIPH_TKEY2_VAL         8'h5F
`define DSIPH_REG_RST_VAL       8'h00
`define DSIPH_VERSION_DEF       8'h5A
// ----------------------------------------
// timing, clock 100 MHz
// ----------------------------------------
`define DSIPH_CLK_MHZ           100
`define DSIPH_LOAD_TIME_US      5000
`define DSIPH_LOAD_CYCLES       (`DSIPH_LOAD_TIME_US * `DSIPH_CLK_MHZ)
`endif

// [dsiph_pkg.sv]
`include "dsiph_cfg.svh"
package dsiph_pkg;
	// power state of the panel
	typedef enum logic [1:0] {
		DSIPH_ASLEEP  = 2'b00,
		DSIPH_WAKING  = 2'b01,
		DSIPH_AWAKE   = 2'b10
	} dsiph_pwr_t;

	typedef logic [7:0] dsiph_byte_t;

	// map a set-up offset to its slot; 7 means not a staged register
	function automatic logic [2:0] dsiph_slot(input logic [7:0] ofs);
		case (ofs)
			`DSIPH_TERM_SEL_OFS:  dsiph_slot = 3'h0;
			`DSIPH_GCLK_ADJ_OFS:  dsiph_slot = 3'h1;
			`DSIPH_GOE_WIDTH_OFS: dsiph_slot = 3'h2;
			`DSIPH_GATE_SUP_OFS:  dsiph_slot = 3'h3;
			`DSIPH_TKEY1_OFS:     dsiph_slot = 3'h4;
			`DSIPH_TKEY2_OFS:     dsiph_slot = 3'h5;
			`DSIPH_CLK_DRIVE_OFS: dsiph_slot = 3'h6;
			default: dsiph_slot = 3'h7;
		endcase
	endfunction
endpackage

// [dsiph_top.sv]
`timescale 1ns/1ps
`include "dsiph_cfg.svh"
// Operation
// R1 - new register writes stay pending and take effect on the next vsync, except soft reset which acts at once.
// R2 - command 01h with no parameter returns all commands and parameters to reset values.
// R3 - soft reset grounds all source outputs so the display is off.
// R4 - the host waits at least 20 ms after soft reset before the next command.
// R5 - after soft reset the factory defaults are loaded into the registers within 5 ms.
// R6 - sleep entry starts the power-down profile and is ignored when already asleep.
// R7 - sleep exit runs the wake-up profile and reloads the register values.
// R8 - the host waits at least 5 ms after sleep exit before the next command.
// R9 - the version read returns one read-only byte holding the supplier version code; this design gives no answer while asleep.
// R10 - the host sends the set-up writes in order, from B2=7D through D2=64.
// R11 - the host writes 0B to AE to pick the input termination.
// R12 - the host writes 18 to B6 to set the gate enable pulse width.
// R13 - the host unlocks test mode with EE=EA, EF=5F, writes F2=68, then clears EE and EF.
// R14 - writes arrive as short packets with the code first; the version byte goes back as a read response.
module dsiph_top
	import dsiph_pkg::*;
#(
	parameter int          LOAD_CYCLES  = `DSIPH_LOAD_CYCLES,
	parameter int          WAKE_CYCLES  = 16,
	parameter logic [7:0]  VERSION_CODE = `DSIPH_VERSION_DEF // arbitrary value
)(
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         link_clk,
	input  wire logic         link_frame,
	input  wire logic [7:0]   link_data,
	input  wire logic         vsync,
	output logic              rd_valid_r,
	output logic [7:0]        rd_data_r,
	output logic              source_gnd_r,
	output logic              sleep_r,
	output logic              loading_r,
	output logic [55:0]       active_regs_r
);
	localparam int NSLOT = 7;
	localparam int SW    = 11;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [SW-1:0] s1_r;
	logic [SW-1:0] s2_r;
	logic [SW-1:0] s3_r;
	logic [SW-1:0] flt_r;
	logic [SW-1:0] flt_d_r;

	// three stages; a change counts once stages two and three agree
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_r    <= '0;
			s2_r    <= '0;
			s3_r    <= '0;
			flt_r   <= '0;
			flt_d_r <= '0;
		end else begin
			s1_r    <= {vsync, link_frame, link_clk, link_data};
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			flt_r   <= (s2_r & s3_r) | (flt_r & (s2_r | s3_r));
			flt_d_r <= flt_r;
		end
	end

	logic lclk_rise;
	logic frame_end;
	logic vsync_rise;
	logic frame_now;
	assign lclk_rise  = flt_r[8] & ~flt_d_r[8];
	assign frame_now  = flt_r[9];
	assign frame_end  = ~flt_r[9] & flt_d_r[9];
	assign vsync_rise = flt_r[10] & ~flt_d_r[10];

	// ----------------------------------------
	// packet capture
	// ----------------------------------------
	logic [1:0]  cnt_r;
	dsiph_byte_t code_r;
	dsiph_byte_t param_r;

	// code byte first, then one parameter byte; extra bytes dropped [R14]
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r   <= 2'h0;
			code_r  <= 8'h00;
			param_r <= 8'h00;
		end else if (frame_end) begin
			cnt_r <= 2'h0;
		end else if (lclk_rise && frame_now) begin
			if (cnt_r == 2'h0)
				code_r <= flt_r[7:0];
			else if (cnt_r == 2'h1)
				param_r <= flt_r[7:0];
			if (cnt_r != 2'h3)
				cnt_r <= cnt_r + 2'h1;
		end
	end

	logic exec;
	logic is_rst;
	logic is_write;
	logic [2:0] slot;
	assign exec     = frame_end && (cnt_r != 2'h0);
	assign is_rst   = exec && (code_r == `DSIPH_SOFT_RESET_CMD) && (cnt_r == 2'h1);
	assign slot     = dsiph_slot(code_r);
	assign is_write = exec && (cnt_r >= 2'h2) && (slot != 3'h7);

	// ----------------------------------------
	// power state and soft reset loading
	// ----------------------------------------
	dsiph_pwr_t pwr_r;
	logic [31:0] tmr_r;

	// soft reset takes hold at once and restarts the default load [R1] [R2]
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			loading_r <= 1'b0;
			tmr_r     <= '0;
		end else if (is_rst) begin
			loading_r <= 1'b1;
			tmr_r     <= '0;
		end else if (loading_r) begin
			// load finishes inside the window; host keeps quiet meanwhile [R5] [R4]
			if (tmr_r >= 32'(LOAD_CYCLES - 1))
				loading_r <= 1'b0;
			tmr_r <= tmr_r + 32'h1;
		end
	end

	logic [15:0] wake_r;

	// sleep state machine; reset state is sleep-in
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pwr_r  <= DSIPH_ASLEEP;
			wake_r <= '0;
		end else if (is_rst) begin
			pwr_r <= DSIPH_ASLEEP;
		end else begin
			case (pwr_r)
				DSIPH_ASLEEP: begin
					if (exec && code_r == `DSIPH_SLEEP_EXIT_CMD) begin
						pwr_r  <= DSIPH_WAKING; // [R7]
						wake_r <= '0;
					end
				end
				DSIPH_WAKING: begin
					// host holds off the next command meanwhile [R8]
					if (wake_r >= 16'(WAKE_CYCLES - 1))
						pwr_r <= DSIPH_AWAKE;
					wake_r <= wake_r + 16'h1;
				end
				DSIPH_AWAKE: begin
					// a second sleep entry while asleep never reaches here [R6]
					if (exec && code_r == `DSIPH_SLEEP_ENTRY_CMD)
						pwr_r <= DSIPH_ASLEEP;
				end
				default: pwr_r <= DSIPH_ASLEEP;
			endcase
		end
	end

	// sources held at ground unless awake and loaded [R3]
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			source_gnd_r <= 1'b1;
			sleep_r      <= 1'b1;
		end else begin
			source_gnd_r <= is_rst || loading_r || (pwr_r != DSIPH_AWAKE);
			sleep_r      <= (pwr_r == DSIPH_ASLEEP) || is_rst;
		end
	end

	// ----------------------------------------
	// staged set-up registers
	// ----------------------------------------
	dsiph_byte_t pend_r [NSLOT];
	logic        unlocked;
	logic        wr_ok;
	logic        reload;

	// clock-lane drive only writable with both test keys pending [R13]
	assign unlocked = (pend_r[4] == `DSIPH_TKEY1_VAL) && (pend_r[5] == `DSIPH_TKEY2_VAL);
	assign wr_ok    = is_write && ((slot != 3'h6) || unlocked);
	assign reload   = (pwr_r == DSIPH_WAKING) && (wake_r == 16'h0);

	genvar gi;
	generate
		for (gi = 0; gi < NSLOT; gi++) begin : g_slot
			// write lands in pending; copied to active on vsync or wake [R1] [R7]
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					pend_r[gi]                <= `DSIPH_REG_RST_VAL;
					active_regs_r[gi*8 +: 8]  <= `DSIPH_REG_RST_VAL;
				end else if (is_rst) begin
					pend_r[gi]                <= `DSIPH_REG_RST_VAL; // [R2]
					active_regs_r[gi*8 +: 8]  <= `DSIPH_REG_RST_VAL;
				end else begin
					if (wr_ok && slot == 3'(gi))
						pend_r[gi] <= param_r; // [R10] [R11] [R12]
					if (vsync_rise || reload)
						active_regs_r[gi*8 +: 8] <= pend_r[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// version read response
	// ----------------------------------------
	// no answer while asleep; one-cycle pulse with the byte
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_valid_r <= 1'b0;
			rd_data_r  <= 8'h00;
		end else begin
			rd_valid_r <= exec && (code_r == `DSIPH_VERSION_READ_CMD) && (pwr_r != DSIPH_ASLEEP); // [R9] [R14]
			rd_data_r  <= VERSION_CODE;
		end
	end
endmodule

// [dsiph_host.sv]
`timescale 1ns/1ps
// ----------------------------------------
// host link model
// ----------------------------------------
module dsiph_host (
	output logic       link_clk,
	output logic       link_frame,
	output logic [7:0] link_data
);
	// idle: clock parked low between frames
	initial begin
		link_clk = 1'b0;
		link_frame = 1'b0;
		link_data = 8'hFF;
	end
	// short packet, code byte first
	task automatic send(input int n, input logic [15:0] w);
		link_frame = 1'b1;
		for (int i = 0; i < n; i++) begin
			link_data = w[15 - 8 * i -: 8];
			#80 link_clk = 1'b1;
			#80 link_clk = 1'b0;
		end
		link_data = ~link_data; // released bus must not look held
		#40 link_frame = 1'b0;
		#120;
	endtask
endmodule

// [dsiph_monitor.sv]
`timescale 1ns/1ps
module dsiph_monitor
	import dsiph_pkg::*;
#(
	parameter int         LOAD_CYCLES  = 50,
	parameter logic [7:0] VERSION_CODE = 8'h5A // arbitrary value
)(
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        rd_valid_r,
	input wire logic [7:0]  rd_data_r,
	input wire logic        source_gnd_r,
	input wire logic        sleep_r,
	input wire logic        loading_r,
	input wire logic [55:0] active_regs_r
);
	// ----------------------------------------
	// load-time counter
	// ----------------------------------------
	int ld_cnt_r;
	// counts high cycles; a repetition would be far too long
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			ld_cnt_r <= 0;
		else
			ld_cnt_r <= loading_r ? ld_cnt_r + 1 : 0;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence srst_s; $rose(loading_r); endsequence
	sequence wake_s; $fell(sleep_r) && !loading_r; endsequence
	AST_RD_PULSE: assert property (rd_valid_r |=> !rd_valid_r) else $error("long read pulse");
	AST_RD_CODE: assert property (rd_valid_r |-> rd_data_r == VERSION_CODE) else $error("bad version");
	AST_RD_AWAKE: assert property (rd_valid_r |-> !sleep_r) else $error("read while asleep");
	AST_SRST: assert property (srst_s |-> active_regs_r == '0 && source_gnd_r && sleep_r)
		else $error("soft reset state wrong");
	AST_LOAD_GND: assert property (loading_r |-> source_gnd_r) else $error("display on while loading");
	AST_LOAD_MAX: assert property (loading_r |-> ld_cnt_r <= LOAD_CYCLES) else $error("load too long");
	AST_LOAD_END: assert property ($fell(loading_r) |-> ld_cnt_r >= LOAD_CYCLES - 1) else $error("load short");
	AST_WAKE: assert property (wake_s |-> source_gnd_r [*8] ##[1:12] !source_gnd_r) else $error("wake length");
	AST_DISP_ON: assert property ($fell(source_gnd_r) |-> !sleep_r && !loading_r) else $error("early on");
endmodule
bind dsiph_top dsiph_monitor #(.LOAD_CYCLES(LOAD_CYCLES), .VERSION_CODE(VERSION_CODE)) u_mon (.clk(clk),
	.resetn(resetn), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r), .source_gnd_r(source_gnd_r),
	.sleep_r(sleep_r), .loading_r(loading_r), .active_regs_r(active_regs_r));

// [dsiph_top_tb.sv]
`timescale 1ns/1ps
`include "dsiph_cfg.svh"
module dsiph_top_tb
	import dsiph_pkg::*;
;
	// ----------------------------------------
	// bench, model and checks
	// ----------------------------------------
	logic        clk, resetn, vsync, rd_valid_r, source_gnd_r, sleep_r, loading_r, link_clk, link_frame;
	logic [7:0]  link_data, rd_data_r;
	logic [55:0] active_regs_r;
	int          err_total, comparisons, cyc, seed, rd_cnt;
	dsiph_byte_t pend[7], act[7], rd_last, r;
	dsiph_byte_t ofs[7] = '{8'hAE, 8'hB2, 8'hB6, 8'hD2, 8'hEE, 8'hEF, 8'hF2};
	logic [15:0] sq[9] = '{16'hB27D, 16'hAE0B, 16'hB618, 16'hEEEA, 16'hEF5F, 16'hF268, 16'hEE00, 16'hEF00, 16'hD264};
	dsiph_top #(.LOAD_CYCLES(50)) uut (.clk(clk), .resetn(resetn), .link_clk(link_clk), .link_frame(link_frame),
		.link_data(link_data), .vsync(vsync), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r),
		.source_gnd_r(source_gnd_r), .sleep_r(sleep_r), .loading_r(loading_r), .active_regs_r(active_regs_r));
	dsiph_host host (.link_clk(link_clk), .link_frame(link_frame), .link_data(link_data));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// read pulses caught mid-cycle, where outputs are settled; hang ceiling
	always @(negedge clk) begin
		cyc++;
		if (rd_valid_r === 1'b1) begin
			rd_cnt++;
			rd_last = rd_data_r;
		end
		if (cyc == 30000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic chk_v(input logic [55:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t value %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic got, exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t flag %b want %b", $time, got, exp);
		end
	endtask
	function automatic logic [55:0] expv();
		for (int k = 0; k < 7; k++)
			expv[8 * k +: 8] = act[k];
	endfunction
	// model: staged writes, F2 only behind both keys
	task automatic wr(input int n, input dsiph_byte_t c, p);
		@(posedge clk) #1; // frames always start just after an edge
		host.send(n, {c, p});
		if (n == 1 && c == 8'h01) begin
			pend = '{default: 8'h00};
			act = pend;
		end
		if (c == 8'h11)
			act = pend;
		for (int k = 0; k < 7; k++)
			if (n == 2 && c == ofs[k] && (k != 6 || (pend[4] == 8'hEA && pend[5] == 8'h5F)))
				pend[k] = p;
	endtask
	task automatic vs();
		@(posedge clk) #1 vsync = 1'b1;
		repeat (6) @(posedge clk);
		#1 vsync = 1'b0;
		repeat (6) @(posedge clk);
		act = pend;
	endtask
	task automatic tally_and_finish();
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// main sequence
	initial begin
		seed = 38675;
		resetn = 1'b0;
		vsync = 1'b0;
		pend = '{default: 8'h00};
		act = pend;
		repeat (5) @(posedge clk);
		#1 resetn = 1'b1;
		chk_b(sleep_r, 1'b1);
		chk_b(source_gnd_r, 1'b1);
		wr(1, 8'h90, 8'h00);
		chk_v(56'(rd_cnt), 56'd0);
		wr(2, 8'hB2, 8'h7D);
		wr(1, 8'h11, 8'h00);
		chk_v(active_regs_r, expv());
		repeat (20) @(posedge clk); // host wait after wake
		chk_b(source_gnd_r, 1'b0);
		foreach (sq[i]) wr(2, sq[i][15:8], sq[i][7:0]);
		chk_v(active_regs_r, expv());
		vs();
		chk_v(active_regs_r, expv());
		r = 8'($random(seed));
		wr(2, 8'hF2, r);
		wr(2, 8'h55, r);
		wr(2, 8'hB6, r ^ 8'h3C);
		vs();
		chk_v(active_regs_r, expv());
		wr(1, 8'h90, 8'h00);
		chk_v(56'(rd_cnt), 56'd1);
		chk_v(56'(rd_last), 56'(`DSIPH_VERSION_DEF));
		wr(1, 8'h10, 8'h00);
		wr(1, 8'h10, 8'h00);
		chk_b(sleep_r, 1'b1);
		wr(1, 8'h11, 8'h00);
		repeat (20) @(posedge clk); // host wait after wake
		wr(2, 8'h01, r);
		chk_v(active_regs_r, expv());
		wr(1, 8'h01, 8'h00);
		chk_v(active_regs_r, expv());
		chk_b(source_gnd_r, 1'b1);
		for (int i = 0; i < 60 && loading_r !== 1'b0; i++) @(posedge clk) #1; // host wait after reset
		chk_b(loading_r, 1'b0);
		tally_and_finish();
	end
endmodule
